/* File: hdl/tcr_pkg.sv */
// Purpose: Shared constants and types for the transceiver config register bank
// Assumes: Avalon-MM slave with 8-bit register data in the low byte of a 32-bit word
// Notes:   Offsets printed are register indices; byte address is four times the index
package tcr_pkg;
    // Register indices
    localparam logic [6:0] TCR_IDX_FIFO    = 7'h00;
    localparam logic [6:0] TCR_IDX_OPMODE  = 7'h01;
    localparam logic [6:0] TCR_IDX_RATE_HI = 7'h02;
    localparam logic [6:0] TCR_IDX_RATE_LO = 7'h03;
    localparam logic [6:0] TCR_IDX_DEV_HI  = 7'h04;
    localparam logic [6:0] TCR_IDX_DEV_LO  = 7'h05;
    localparam logic [6:0] TCR_IDX_CARR_HI = 7'h06;
    localparam logic [6:0] TCR_IDX_CARR_MI = 7'h07;
    localparam logic [6:0] TCR_IDX_CARR_LO = 7'h08;
    localparam logic [6:0] TCR_IDX_IRQ1    = 7'h3e;
    localparam logic [6:0] TCR_IDX_IRQ2    = 7'h3f;
    localparam logic [6:0] TCR_IDX_ROUTE_L = 7'h40;
    localparam logic [6:0] TCR_IDX_ROUTE_H = 7'h41;
    localparam logic [6:0] TCR_IDX_REV     = 7'h42;
    localparam logic [6:0] TCR_IDX_GAIN_R  = 7'h43;
    localparam logic [6:0] TCR_IDX_GAIN_1  = 7'h44;
    localparam logic [6:0] TCR_IDX_GAIN_2  = 7'h45;
    localparam logic [6:0] TCR_IDX_GAIN_3  = 7'h46;
    localparam logic [6:0] TCR_IDX_HOP     = 7'h4b;
    localparam logic [6:0] TCR_IDX_REFIN   = 7'h58;
    localparam logic [6:0] TCR_IDX_AMP     = 7'h5a;
    localparam logic [6:0] TCR_IDX_LOOP    = 7'h5c;
    localparam logic [6:0] TCR_IDX_LOOP_LN = 7'h5e;
    localparam logic [6:0] TCR_IDX_TEMP    = 7'h6c;
    localparam logic [6:0] TCR_IDX_FRAC    = 7'h70;
    localparam logic [6:0] TCR_IDX_IRQMASK = 7'h71;
    // Reset values
    localparam logic [7:0] TCR_RST_OPMODE  = 8'h01;
    localparam logic [7:0] TCR_RST_RATE_HI = 8'h1a;
    localparam logic [7:0] TCR_RST_RATE_LO = 8'h0b;
    localparam logic [7:0] TCR_RST_DEV_HI  = 8'h00;
    localparam logic [7:0] TCR_RST_DEV_LO  = 8'h52;
    localparam logic [7:0] TCR_RST_CARR_HI = 8'he4;
    localparam logic [7:0] TCR_RST_CARR_MI = 8'hc0;
    localparam logic [7:0] TCR_RST_CARR_LO = 8'h00;
    localparam logic [7:0] TCR_RST_ROUTE   = 8'h00;
    localparam logic [7:0] TCR_RST_GAIN_R  = 8'h13;
    localparam logic [7:0] TCR_RST_GAIN_1  = 8'h0e;
    localparam logic [7:0] TCR_RST_GAIN_2  = 8'h5b;
    localparam logic [7:0] TCR_RST_GAIN_3  = 8'hdb;
    localparam logic [7:0] TCR_RST_HOP     = 8'h2e;
    localparam logic [7:0] TCR_RST_REFIN   = 8'h09;
    localparam logic [7:0] TCR_RST_AMP     = 8'h84;
    localparam logic [7:0] TCR_RST_LOOP    = 8'hd0;
    localparam logic [7:0] TCR_RST_FRAC    = 8'h00;
    localparam logic [7:0] TCR_RST_MASK    = 8'h00;
    localparam logic [7:0] TCR_RST_ST2     = 8'h40;
    // Field positions
    localparam int TCR_MODE_LSB  = 0;
    localparam int TCR_SHAPE_LSB = 3;
    localparam int TCR_MOD_LSB   = 5;
    localparam int TCR_DEV_HI_W  = 6;
    // Status bit positions: three in irq_status_one, four in irq_status_two
    localparam int TCR_ST1_LOCK    = 4;
    localparam int TCR_ST1_TIMEOUT = 2;
    localparam int TCR_ST1_RSSI    = 3;
    localparam int TCR_ST2_FULL    = 7;
    localparam int TCR_ST2_EMPTY   = 6;
    localparam int TCR_ST2_OVERRUN = 4;
    localparam int TCR_ST2_LOWBAT  = 0;
    // Fifo depth and bus answer
    localparam int          TCR_FIFO_DEPTH = 16;
    localparam logic [31:0] TCR_UNMAPPED   = 32'h0000_0000;

    typedef enum logic [2:0] {
        TCR_SLEEP, TCR_STANDBY, TCR_SYNTH_TX_PREP, TCR_TRANSMIT,
        TCR_SYNTH_RX_PREP, TCR_RECEIVE, TCR_RSVD6, TCR_RSVD7
    } tcr_opstate_type;
    typedef enum logic [1:0] {TCR_FSK, TCR_OOK, TCR_MOD_RSVD2, TCR_MOD_RSVD3} tcr_mod_type;
    typedef enum logic [2:0] {
        TCR_SH_NONE, TCR_SH_GAUSS_10, TCR_SH_GAUSS_05, TCR_SH_GAUSS_03,
        TCR_SH_CUT_1X, TCR_SH_CUT_2X, TCR_SH_INVALID
    } tcr_shape_type;

    typedef struct packed {
        logic [8:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } tcr_avs_req_type;
    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } tcr_avs_rsp_type;
    typedef struct packed {
        logic lock;
        logic timeout;
        logic rssi_over;
        logic low_battery;
        logic restart_rx;
    } tcr_events_type;
    typedef struct packed {
        tcr_opstate_type op_state;
        tcr_mod_type     modulation;
        tcr_shape_type   shaping;
        logic [19:0]     rate_divider_q4;
        logic [13:0]     freq_deviation;
        logic [23:0]     carrier_freq_word;
        logic [15:0]     pin_route;
        logic [7:0]      hop_control;
        logic [7:0]      ref_input;
        logic [7:0]      amp_high_power;
        logic [7:0]      loop_bw;
        logic [7:0]      loop_bw_low_noise;
        logic [31:0]     gain_settings;
    } tcr_config_type;
endpackage

/* File: hdl/tcr_regs.sv */
// Purpose: Byte-wide configuration and status register bank of a packet transceiver
// Assumes: Avalon-MM slave, one word per register, single clock, synchronous reset
// Notes:   Fifo storage is flip-flops; status flags are write-one-to-clear except lock, full and empty
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
module tcr_regs #(
    parameter logic [7:0] REVISION_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] TEMP_STORED   = 8'h00
) (
    // Clock and reset
    input  wire logic                     ref_clk_in,
    input  wire logic                     sys_rst_in,
    // Register bus
    input  wire tcr_pkg::tcr_avs_req_type avs_req_in,
    output tcr_pkg::tcr_avs_rsp_type      avs_rsp_out,
    // Events from the radio core
    input  wire tcr_pkg::tcr_events_type  events_in,
    // Configuration to the radio core
    output tcr_pkg::tcr_config_type       config_out,
    output logic                          irq_out
);
    import tcr_pkg::*;

    typedef struct packed {
        logic [TCR_FIFO_DEPTH-1:0][7:0] fifo_mem;
        logic [3:0]  wr_ptr;
        logic [3:0]  rd_ptr;
        logic [4:0]  count;
        logic [7:0]  opmode;
        logic [7:0]  rate_hi;
        logic [7:0]  rate_lo;
        logic [7:0]  dev_hi;
        logic [7:0]  dev_lo;
        logic [23:0] carr_reg;
        logic [23:0] carr_applied;
        logic [7:0]  st1;
        logic [7:0]  st2;
        logic [7:0]  mask;
        logic [15:0] route;
        logic [31:0] gain;
        logic [7:0]  hop;
        logic [7:0]  refin;
        logic [7:0]  amp;
        logic [7:0]  loop_bw;
        logic [7:0]  loop_ln;
        logic [7:0]  frac;
        logic        ack;
        logic [31:0] rdata;
        logic [1:0]  ev_sync_a;
        logic [1:0]  ev_sync_b;
    } tcr_state_type;

    tcr_state_type state;
    tcr_state_type next_state;
    logic [6:0]    idx;
    logic          access;
    logic          wr_acc;
    logic          rd_acc;
    logic [7:0]    wbyte;

    function automatic tcr_shape_type decode_shape(input logic [1:0] mk, input logic [1:0] sh);
        tcr_shape_type s;
        s = TCR_SH_INVALID;
        if (mk == 2'h0) begin
            s = tcr_shape_type'({1'b0, sh});
        end else if (mk == 2'h1) begin
            case (sh)
                2'h0:    s = TCR_SH_NONE;
                2'h1:    s = TCR_SH_CUT_1X;
                2'h2:    s = TCR_SH_CUT_2X;
                default: s = TCR_SH_INVALID;
            endcase
        end
        return s;
    endfunction

    function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] clr,
                                       input logic [7:0] set);
        return (cur & ~clr) | set;
    endfunction

    // Readback mux
    function automatic logic [7:0] read_byte(input tcr_state_type s, input logic [6:0] i);
        logic [7:0] v;
        v = 8'h00;
        case (i)
            TCR_IDX_FIFO:    v = s.fifo_mem[s.rd_ptr];
            TCR_IDX_OPMODE:  v = s.opmode;
            TCR_IDX_RATE_HI: v = s.rate_hi;
            TCR_IDX_RATE_LO: v = s.rate_lo;
            TCR_IDX_DEV_HI:  v = s.dev_hi;
            TCR_IDX_DEV_LO:  v = s.dev_lo;
            TCR_IDX_CARR_HI: v = s.carr_reg[23:16];
            TCR_IDX_CARR_MI: v = s.carr_reg[15:8];
            TCR_IDX_CARR_LO: v = s.carr_reg[7:0];
            TCR_IDX_IRQ1:    v = s.st1;
            TCR_IDX_IRQ2:    v = s.st2;
            TCR_IDX_ROUTE_L: v = s.route[7:0];
            TCR_IDX_ROUTE_H: v = s.route[15:8];
            TCR_IDX_REV:     v = REVISION_CODE;
            TCR_IDX_GAIN_R:  v = s.gain[7:0];
            TCR_IDX_GAIN_1:  v = s.gain[15:8];
            TCR_IDX_GAIN_2:  v = s.gain[23:16];
            TCR_IDX_GAIN_3:  v = s.gain[31:24];
            TCR_IDX_HOP:     v = s.hop;
            TCR_IDX_REFIN:   v = s.refin;
            TCR_IDX_AMP:     v = s.amp;
            TCR_IDX_LOOP:    v = s.loop_bw;
            TCR_IDX_LOOP_LN: v = s.loop_ln;
            TCR_IDX_TEMP:    v = TEMP_STORED;
            TCR_IDX_FRAC:    v = s.frac;
            TCR_IDX_IRQMASK: v = s.mask;
            default:         v = TCR_UNMAPPED[7:0];
        endcase
        return v;
    endfunction

    assign idx    = avs_req_in.address[8:2];
    assign access = (avs_req_in.read | avs_req_in.write) & ~state.ack;
    // Writes land at the edge where waitrequest is already low
    assign wr_acc = avs_req_in.write & state.ack;
    assign rd_acc = access & avs_req_in.read;
    assign wbyte  = avs_req_in.writedata[7:0];

    always_comb begin
        logic [7:0] set1;
        logic [7:0] set2;
        logic [7:0] clr1;
        logic [7:0] clr2;
        logic       push;
        logic       pop;
        logic [2:0] new_mode;
        set1 = 8'h00;
        set2 = 8'h00;
        clr1 = 8'h00;
        clr2 = 8'h00;
        push = 1'b0;
        pop = 1'b0;
        new_mode = 3'h0;
        next_state = state;
        next_state.ack = access;
        next_state.ev_sync_a = {events_in.timeout, events_in.rssi_over};
        next_state.ev_sync_b = state.ev_sync_a;
        if (rd_acc) begin
            next_state.rdata = {24'h0, read_byte(state, idx)};
        end
        // Fifo push and pop through index zero
        if (idx == TCR_IDX_FIFO) begin
            push = wr_acc;
            pop  = rd_acc;
        end
        if (push && state.count == 5'(TCR_FIFO_DEPTH)) begin
            set2[TCR_ST2_OVERRUN] = 1'b1;
            push = 1'b0;
        end
        if (pop && state.count == 5'h0) begin
            pop = 1'b0;
        end
        if (push) begin
            next_state.fifo_mem[state.wr_ptr] = wbyte;
            next_state.wr_ptr = state.wr_ptr + 4'h1;
        end
        if (pop) begin
            next_state.rd_ptr = state.rd_ptr + 4'h1;
        end
        next_state.count = state.count + 5'(push) - 5'(pop);
        // Plain register writes
        if (wr_acc) begin
            case (idx)
                TCR_IDX_OPMODE:  next_state.opmode = {1'b0, wbyte[6:0]};
                TCR_IDX_RATE_HI: next_state.rate_hi = wbyte;
                TCR_IDX_RATE_LO: next_state.rate_lo = wbyte;
                TCR_IDX_DEV_HI:  next_state.dev_hi = {2'b00, wbyte[5:0]};
                TCR_IDX_DEV_LO:  next_state.dev_lo = wbyte;
                TCR_IDX_CARR_HI: next_state.carr_reg[23:16] = wbyte;
                TCR_IDX_CARR_MI: next_state.carr_reg[15:8] = wbyte;
                TCR_IDX_CARR_LO: next_state.carr_reg[7:0] = wbyte;
                TCR_IDX_IRQ1:    clr1 = wbyte;
                TCR_IDX_IRQ2:    clr2 = wbyte;
                TCR_IDX_ROUTE_L: next_state.route[7:0] = wbyte;
                TCR_IDX_ROUTE_H: next_state.route[15:8] = wbyte;
                TCR_IDX_GAIN_R:  next_state.gain[7:0] = wbyte;
                TCR_IDX_GAIN_1:  next_state.gain[15:8] = wbyte;
                TCR_IDX_GAIN_2:  next_state.gain[23:16] = wbyte;
                TCR_IDX_GAIN_3:  next_state.gain[31:24] = wbyte;
                TCR_IDX_HOP:     next_state.hop = wbyte;
                TCR_IDX_REFIN:   next_state.refin = wbyte;
                TCR_IDX_AMP:     next_state.amp = wbyte;
                TCR_IDX_LOOP:    next_state.loop_bw = wbyte;
                TCR_IDX_LOOP_LN: next_state.loop_ln = wbyte;
                TCR_IDX_FRAC:    next_state.frac = {4'h0, wbyte[3:0]};
                TCR_IDX_IRQMASK: next_state.mask = wbyte;
                default:         next_state.mask = state.mask;
            endcase
        end
        // Carrier word takes effect on entry to a prep state or receiver restart
        new_mode = next_state.opmode[2:0];
        if ((new_mode != state.opmode[2:0]
             && (new_mode == 3'h2 || new_mode == 3'h4))
            || events_in.restart_rx) begin
            next_state.carr_applied = next_state.carr_reg;
        end
        // Status flags: set wins over clear
        set1[TCR_ST1_TIMEOUT] = state.ev_sync_b[1];
        set1[TCR_ST1_RSSI]    = state.ev_sync_b[0];
        next_state.st1 = w1c(state.st1, clr1, set1);
        next_state.st1[TCR_ST1_LOCK] = events_in.lock;
        set2[TCR_ST2_LOWBAT] = events_in.low_battery;
        next_state.st2 = w1c(state.st2, clr2, set2);
        next_state.st2[TCR_ST2_FULL]  = next_state.count == 5'(TCR_FIFO_DEPTH);
        next_state.st2[TCR_ST2_EMPTY] = next_state.count == 5'h0;
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state <= '0;
            state.opmode <= TCR_RST_OPMODE;
            state.rate_hi <= TCR_RST_RATE_HI;
            state.rate_lo <= TCR_RST_RATE_LO;
            state.dev_hi <= TCR_RST_DEV_HI;
            state.dev_lo <= TCR_RST_DEV_LO;
            state.carr_reg <= {TCR_RST_CARR_HI, TCR_RST_CARR_MI, TCR_RST_CARR_LO};
            state.carr_applied <= {TCR_RST_CARR_HI, TCR_RST_CARR_MI, TCR_RST_CARR_LO};
            state.st2 <= TCR_RST_ST2;
            state.route <= {TCR_RST_ROUTE, TCR_RST_ROUTE};
            state.gain <= {TCR_RST_GAIN_3, TCR_RST_GAIN_2, TCR_RST_GAIN_1, TCR_RST_GAIN_R};
            state.hop <= TCR_RST_HOP;
            state.refin <= TCR_RST_REFIN;
            state.amp <= TCR_RST_AMP;
            state.loop_bw <= TCR_RST_LOOP;
            state.loop_ln <= TCR_RST_LOOP;
            state.frac <= TCR_RST_FRAC;
            state.mask <= TCR_RST_MASK;
        end else begin
            state <= next_state;
        end
    end

    // Outputs
    assign avs_rsp_out.waitrequest = ~state.ack & (avs_req_in.read | avs_req_in.write);
    assign avs_rsp_out.readdata    = state.rdata;
    assign irq_out                 = |({state.st1, state.st2} & {state.mask, state.mask});
    assign config_out.op_state     = tcr_opstate_type'(state.opmode[2:0]);
    assign config_out.modulation   = tcr_mod_type'(state.opmode[6:5]);
    assign config_out.shaping      = decode_shape(state.opmode[6:5], state.opmode[4:3]);
    assign config_out.rate_divider_q4 = {state.rate_hi, state.rate_lo, state.frac[3:0]};
    assign config_out.freq_deviation  = {state.dev_hi[5:0], state.dev_lo};
    assign config_out.carrier_freq_word = state.carr_applied;
    assign config_out.pin_route      = state.route;
    assign config_out.hop_control    = state.hop;
    assign config_out.ref_input      = state.refin;
    assign config_out.amp_high_power = state.amp;
    assign config_out.loop_bw        = state.loop_bw;
    assign config_out.loop_bw_low_noise = state.loop_ln;
    assign config_out.gain_settings  = state.gain;

    property p_wait_one;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (avs_req_in.read && !state.ack) |-> avs_rsp_out.waitrequest ##1 !avs_rsp_out.waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest not one cycle");

    property p_rev;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (avs_req_in.read && idx == TCR_IDX_REV && !state.ack)
            |=> avs_rsp_out.readdata[7:0] == REVISION_CODE;
    endproperty
    a_rev: assert property (p_rev) else $error("revision readback wrong");

    property p_reset_mode;
        @(posedge ref_clk_in) sys_rst_in |=> config_out.op_state == TCR_STANDBY;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset mode not standby");

    property p_dev_reset;
        @(posedge ref_clk_in) sys_rst_in |=> config_out.freq_deviation == 14'h0052;
    endproperty
    a_dev_reset: assert property (p_dev_reset) else $error("deviation reset wrong");

    property p_lowbat;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        events_in.low_battery |=> state.st2[TCR_ST2_LOWBAT];
    endproperty
    a_lowbat: assert property (p_lowbat) else $error("low battery flag lost");

    sequence s_timeout_seen;
        events_in.timeout ##2 1'b1;
    endsequence
    property p_timeout;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        s_timeout_seen |=> state.st1[TCR_ST1_TIMEOUT];
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout flag lost");

    property p_carrier_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (!events_in.restart_rx && !(wr_acc && idx == TCR_IDX_OPMODE))
            |=> $stable(config_out.carrier_freq_word);
    endproperty
    a_carrier_hold: assert property (p_carrier_hold) else $error("carrier changed");

    property p_fifo_empty;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state.count == 5'h0) |-> state.st2[TCR_ST2_EMPTY];
    endproperty
    a_fifo_empty: assert property (p_fifo_empty) else $error("empty flag wrong");

    property p_overrun;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (wr_acc && idx == TCR_IDX_FIFO && state.count == 5'(TCR_FIFO_DEPTH))
            |=> state.st2[TCR_ST2_OVERRUN];
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun flag not set");

    property p_full;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (state.count == 5'(TCR_FIFO_DEPTH)) |-> state.st2[TCR_ST2_FULL];
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");

    property p_clear_one;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (wr_acc && idx == TCR_IDX_IRQ2 && wbyte[TCR_ST2_OVERRUN])
            |=> !state.st2[TCR_ST2_OVERRUN];
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("flag not cleared");

    sequence s_enter_prep;
        wr_acc && idx == TCR_IDX_OPMODE && wbyte[2:0] != state.opmode[2:0]
            && (wbyte[2:0] == 3'h2 || wbyte[2:0] == 3'h4);
    endsequence
    property p_carrier_apply;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        s_enter_prep |=> config_out.carrier_freq_word == state.carr_reg;
    endproperty
    a_carrier_apply: assert property (p_carrier_apply) else $error("carrier not applied");

    property p_restart_apply;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (events_in.restart_rx && !wr_acc)
            |=> config_out.carrier_freq_word == state.carr_reg;
    endproperty
    a_restart_apply: assert property (p_restart_apply) else $error("restart not applied");

    property p_wait_write;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (avs_req_in.write && !state.ack)
            |-> avs_rsp_out.waitrequest ##1 !avs_rsp_out.waitrequest;
    endproperty
    a_wait_write: assert property (p_wait_write) else $error("write wait wrong");

    property p_frac_low;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        (wr_acc && idx == TCR_IDX_FRAC)
            |=> config_out.rate_divider_q4[3:0] == 4'($past(wbyte));
    endproperty
    a_frac_low: assert property (p_frac_low) else $error("rate fraction wrong");

    property p_lock_mirror;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        1'b1 |=> state.st1[TCR_ST1_LOCK] == $past(events_in.lock);
    endproperty
    a_lock_mirror: assert property (p_lock_mirror) else $error("lock flag wrong");
endmodule

/* File: testbench/tcr_regs_bench.sv */
// Purpose: Self-checking bench for the transceiver register bank
// Assumes: Avalon-MM master holding each request until waitrequest is low
// Notes:   Offsets go out as byte addresses; two reset reads, then table rows, then hand cases
`timescale 1ns/1ps
module tcr_regs_bench;
    import tcr_pkg::*;
    localparam logic [7:0] REV  = 8'h3c; // Arbitrary value
    localparam logic [7:0] TEMP = 8'h27;
    typedef struct packed {
        logic [6:0] idx;
        logic [7:0] rst;
        logic [7:0] wv;
        logic [7:0] rb;
    } tcr_row_type;
    logic            ref_clk_in;
    logic            sys_rst_in;
    tcr_avs_req_type req;
    tcr_avs_rsp_type rsp;
    tcr_events_type  ev;
    tcr_config_type  cfg;
    logic            irq;
    logic [31:0]     rdw;
    int              err_total = 0;
    int              checked   = 0;
    int              cycles    = 0;
    tcr_row_type     rows [19];

    tcr_regs #(.REVISION_CODE(REV), .TEMP_STORED(TEMP)) u_dut (
        .ref_clk_in  (ref_clk_in),
        .sys_rst_in  (sys_rst_in),
        .avs_req_in  (req),
        .avs_rsp_out (rsp),
        .events_in   (ev),
        .config_out  (cfg),
        .irq_out     (irq)
    );

    initial begin
        ref_clk_in = 1'b0;
        forever #50 ref_clk_in = ~ref_clk_in;
    end

    task automatic tally_and_finish;
        if (err_total == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            $display("MISMATCH run_length expected below 6000 seen %0d", cycles);
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One Avalon transfer, held until waitrequest is seen low, then one idle edge
    task automatic bus(input logic wr, input logic [6:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        req.address   <= {idx, 2'b00};
        req.read      <= ~wr;
        req.write     <= wr;
        req.writedata <= {24'h0, wd};
        @(posedge ref_clk_in);
        while (rsp.waitrequest !== 1'b0 && n < 40) begin
            @(posedge ref_clk_in);
            n++;
        end
        chk("waitrequest", 32'h0, {31'h0, rsp.waitrequest});
        rdw = rsp.readdata;
        req.read  <= 1'b0;
        req.write <= 1'b0;
        @(posedge ref_clk_in);
    endtask

    task automatic rdchk(input logic [6:0] idx, input logic [7:0] msk, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk("readdata", {24'h0, exp}, rdw & {24'h0, msk});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask

    initial begin
        int         i;
        logic [2:0] md;
        logic [2:0] sh;
        logic [7:0] wv;
        rows = '{'{7'h02, 8'h1a, 8'h5c, 8'h5c}, '{7'h03, 8'h0b, 8'ha3, 8'ha3},
                 '{7'h04, 8'h00, 8'hff, 8'h3f}, '{7'h05, 8'h52, 8'h7e, 8'h7e},
                 '{7'h40, 8'h00, 8'hc3, 8'hc3}, '{7'h41, 8'h00, 8'h35, 8'h35},
                 '{7'h42, REV, 8'h33, REV},     '{7'h43, 8'h13, 8'h21, 8'h21},
                 '{7'h44, 8'h0e, 8'h42, 8'h42}, '{7'h45, 8'h5b, 8'h18, 8'h18},
                 '{7'h46, 8'hdb, 8'h9a, 8'h9a}, '{7'h4b, 8'h2e, 8'h61, 8'h61},
                 '{7'h58, 8'h09, 8'h19, 8'h19}, '{7'h5a, 8'h84, 8'h87, 8'h87},
                 '{7'h5c, 8'hd0, 8'h50, 8'h50}, '{7'h5e, 8'hd0, 8'h55, 8'h55},
                 '{7'h6c, TEMP, 8'h77, TEMP},   '{7'h70, 8'h00, 8'h0c, 8'h0c},
                 '{7'h7f, 8'h00, 8'h99, 8'h00}};
        req = '0;
        ev = '0;
        sys_rst_in = 1'b1;
        tick(4);
        sys_rst_in <= 1'b0;
        tick(1);
        rdchk(7'h01, 8'hff, 8'h01);
        rdchk(7'h71, 8'hff, 8'h00);
        for (i = 0; i < 19; i++) begin
            rdchk(rows[i].idx, 8'hff, rows[i].rst);
        end
        for (i = 0; i < 19; i++) begin
            bus(1'b1, rows[i].idx, rows[i].wv);
        end
        for (i = 0; i < 19; i++) begin
            rdchk(rows[i].idx, 8'hff, rows[i].rb);
        end
        chk("rate", 32'h0005ca3c, {12'h0, cfg.rate_divider_q4});
        chk("deviation", 32'h00003f7e, {18'h0, cfg.freq_deviation});
        chk("pin_route", 32'h000035c3, {16'h0, cfg.pin_route});
        chk("gain", 32'h9a184221, cfg.gain_settings);
        chk("misc", 32'h61198750, {cfg.hop_control, cfg.ref_input,
            cfg.amp_high_power, cfg.loop_bw});
        chk("loop_ln", 32'h00000055, {24'h0, cfg.loop_bw_low_noise});
        for (i = 0; i < 8; i++) begin
            md = 3'(i % 6);
            sh = (i < 4) ? 3'(i) : (i == 4) ? 3'h0 : (i == 7) ? 3'h6 : 3'(i - 1);
            wv = {2'b00, i[2], i[1:0], md};
            bus(1'b1, 7'h01, wv);
            rdchk(7'h01, 8'hff, wv);
            chk("op_state", {29'h0, md}, {29'h0, cfg.op_state});
            chk("modulation", {30'h0, 1'b0, i[2]}, {30'h0, cfg.modulation});
            chk("shaping", {29'h0, sh}, {29'h0, cfg.shaping});
        end
        bus(1'b1, 7'h06, 8'h6c);
        bus(1'b1, 7'h07, 8'h80);
        chk("carrier", 32'h00e4c000, {8'h0, cfg.carrier_freq_word});
        bus(1'b1, 7'h01, 8'h02);
        chk("carrier", 32'h006c8000, {8'h0, cfg.carrier_freq_word});
        bus(1'b1, 7'h06, 8'hd9);
        ev.restart_rx <= 1'b1;
        tick(1);
        ev.restart_rx <= 1'b0;
        tick(2);
        chk("carrier", 32'h00d98000, {8'h0, cfg.carrier_freq_word});
        for (i = 0; i < 17; i++) begin
            bus(1'b1, 7'h00, 8'(8'h10 + i));
        end
        rdchk(7'h3f, 8'hd0, 8'h90);
        for (i = 0; i < 16; i++) begin
            rdchk(7'h00, 8'hff, 8'(8'h10 + i));
        end
        rdchk(7'h3f, 8'hc0, 8'h40);
        bus(1'b1, 7'h3f, 8'h10);
        rdchk(7'h3f, 8'h10, 8'h00);
        ev.low_battery <= 1'b1;
        tick(1);
        ev.low_battery <= 1'b0;
        tick(2);
        rdchk(7'h3f, 8'h01, 8'h01);
        chk("irq_out", 32'h0, {31'h0, irq});
        bus(1'b1, 7'h71, 8'h01);
        chk("irq_out", 32'h1, {31'h0, irq});
        bus(1'b1, 7'h3f, 8'h01);
        rdchk(7'h3f, 8'h01, 8'h00);
        chk("irq_out", 32'h0, {31'h0, irq});
        ev.timeout   <= 1'b1;
        ev.rssi_over <= 1'b1;
        ev.lock      <= 1'b1;
        tick(4);
        ev.timeout   <= 1'b0;
        ev.rssi_over <= 1'b0;
        tick(4);
        rdchk(7'h3e, 8'h1c, 8'h1c);
        ev.lock <= 1'b0;
        bus(1'b1, 7'h3e, 8'h0c);
        rdchk(7'h3e, 8'h1c, 8'h00);
        ev.low_battery <= 1'b1;
        tick(1);
        ev.low_battery <= 1'b0;
        tick(2);
        chk("irq_out", 32'h1, {31'h0, irq});
        sys_rst_in <= 1'b1;
        tick(1);
        sys_rst_in <= 1'b0;
        tick(1);
        chk("irq_out", 32'h0, {31'h0, irq});
        chk("op_state", {29'h0, TCR_STANDBY}, {29'h0, cfg.op_state});
        chk("deviation", 32'h00000052, {18'h0, cfg.freq_deviation});
        chk("rate", 32'h0001a0b0, {12'h0, cfg.rate_divider_q4});
        rdchk(7'h71, 8'hff, 8'h00);
        tally_and_finish();
    end
endmodule
